// ---- inc/prt_pkg.sv ----
// Constants, command codes and carrier types of the prescaler and reload timers
`default_nettype none

package prt_pkg;

  localparam int          CNT_W         = 8;
  localparam int          PER_W         = 16;
  localparam logic [7:0]  CNT_RST       = 8'h00;
  localparam logic [3:0]  CTL_RST       = 4'h0;
  localparam logic [15:0] PER_MAX       = 16'hffff;

  // Control field positions
  localparam int          PA_RUN_BIT    = 0;
  localparam int          SRC_LSB       = 0;
  localparam int          RUN_BIT       = 2;
  localparam int          AUTOSTOP_BIT  = 3;
  localparam int          OUTSEL_BIT    = 3;
  localparam int          T4_SRC_BIT    = 0;
  localparam int          T4_RUN_BIT    = 1;
  localparam int          T4_EXT_BIT    = 2;
  localparam int          T4_OUT_BIT    = 3;
  localparam int          PIN0_FUNC_BIT = 0;
  localparam int          PWM_GATE_BIT  = 1;

  // Two-bit source field codes
  localparam logic [1:0]  SRC_SEL0      = 2'h0;
  localparam logic [1:0]  SRC_SEL1      = 2'h1;
  localparam logic [1:0]  SRC_SEL2      = 2'h2;
  localparam logic [1:0]  SRC_SEL3      = 2'h3;

  typedef enum logic [4:0] {
    OP_NOP                       = 5'h00,
    OP_WRITE_PRESCALER_CONTROL   = 5'h01,
    OP_LOAD_PRESCALER_AND_RELOAD = 5'h02,
    OP_READ_PRESCALER_RELOAD     = 5'h03,
    OP_LOAD_FIRST_TIMER          = 5'h04,
    OP_LOAD_FIRST_RELOAD_ONLY    = 5'h05,
    OP_READ_FIRST_TIMER          = 5'h06,
    OP_LOAD_SECOND_TIMER         = 5'h07,
    OP_READ_SECOND_TIMER         = 5'h08,
    OP_LOAD_THIRD_TIMER          = 5'h09,
    OP_LOAD_THIRD_RELOAD_ONLY    = 5'h0a,
    OP_READ_THIRD_TIMER          = 5'h0b,
    OP_LOAD_FOURTH_TIMER         = 5'h0c,
    OP_LOAD_FOURTH_HIGH_RELOAD   = 5'h0d,
    OP_RESTORE_FOURTH_FROM_LOW   = 5'h0e,
    OP_READ_FOURTH_TIMER         = 5'h0f,
    OP_WRITE_FIRST_CONTROL       = 5'h10,
    OP_WRITE_SECOND_CONTROL      = 5'h11,
    OP_WRITE_THIRD_CONTROL       = 5'h12,
    OP_WRITE_FOURTH_CONTROL      = 5'h13,
    OP_WRITE_PIN_CONTROL         = 5'h14,
    OP_READ_FIRST_CONTROL        = 5'h15,
    OP_READ_SECOND_CONTROL       = 5'h16,
    OP_READ_THIRD_CONTROL        = 5'h17,
    OP_READ_FOURTH_CONTROL       = 5'h18,
    OP_READ_PIN_CONTROL          = 5'h19
  } prt_op_t;

  typedef struct packed {
    logic       valid;
    prt_op_t    op;
    logic [3:0] hi;
    logic [3:0] lo;
  } prt_cmd_t;

  typedef struct packed {
    logic counter_pin_zero;
    logic counter_pin_zero_oe_n;
    logic counter_pin_one;
    logic counter_pin_one_oe_n;
  } prt_pins_t;

endpackage

`default_nettype wire

// ---- verilog/prt_timers.sv ----
// Prescaler and four 8-bit auto-reload timers with PWM and pin outputs
`default_nettype none

module prt_timers
  import prt_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire prt_cmd_t   i_cmd,
  input  wire logic       i_instruction_clock,
  input  wire logic       i_system_clock,
  input  wire logic       i_xin_clock,
  input  wire logic       i_fifth_timer_underflow,
  input  wire logic       i_counter_pin_zero,
  input  wire logic       i_counter_pin_one,
  input  wire logic       i_ext_trigger_pin_zero,
  input  wire logic       i_ext_trigger_pin_one,
  input  wire logic       i_first_irq_pin_control,
  input  wire logic       i_second_irq_pin_control,
  input  wire logic [3:0] i_flag_clr,
  output logic      [7:0] o_rd_data,
  output logic            o_rd_valid,
  output logic      [3:0] o_flags,
  output logic            o_prescaler_output,
  output logic            o_pulse_width_output,
  output prt_pins_t       o_pins
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]       dat;
  logic [7:0]       pre_cnt_r;
  logic [7:0]       pre_rld_r;
  logic             pre_run_r;
  logic             pre_tick;
  logic             pre_uf;
  logic             pre_div2_r;
  logic [3:0]       w1_r;
  logic [3:0]       w2_r;
  logic [3:0]       w3_r;
  logic [3:0]       w4_r;
  logic [3:0]       w6_r;
  logic [7:0]       cnt_r [4];
  logic [7:0]       rld_r [4];
  logic [7:0]       ld_val [4];
  logic [7:0]       rel_val [4];
  logic [3:0]       tick;
  logic [3:0]       uflow;
  logic [3:0]       ld_cnt;
  logic [3:0]       ld_rld;
  logic [7:0]       hi_rld_r;
  logic [3:0]       flag_r;
  logic             sync0_r;
  logic             sync1_r;
  logic             pin0_d_r;
  logic             pin1_d_r;
  logic             pin0_rise;
  logic             pin1_rise;
  logic             pwm_r;
  logic             pwm_d_r;
  logic             pwm_rise;
  logic             gate_r;
  logic             t1_half_r;
  logic             t2_half_r;
  logic             hold4_r;
  logic             src4;
  logic             ext_cond;
  logic             ext_start;
  logic             ext_done;
  logic             ext_wait_r;
  logic [PER_W-1:0] ext_cnt_r;
  logic [PER_W-1:0] per_cnt_r;
  logic [PER_W-1:0] per_r;
  logic [PER_W-1:0] half;
  logic [7:0]       rd_nxt;
  logic             rd_req;
  logic [7:0]       rd_data_r;
  logic             rd_valid_r;
  logic             pre_out_r;
  prt_pins_t        pins_r;

  function automatic logic is_op(input prt_cmd_t c, input prt_op_t o);
    is_op = c.valid && (c.op == o);
  endfunction

  assign dat       = {i_cmd.hi, i_cmd.lo};
  assign pin0_rise = i_counter_pin_zero & ~pin0_d_r;
  assign pin1_rise = i_counter_pin_one & ~pin1_d_r;
  assign pwm_rise  = pwm_r & ~pwm_d_r;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler

  assign pre_tick = pre_run_r & i_instruction_clock;
  assign pre_uf   = pre_tick && (pre_cnt_r == 8'h00);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_cnt_r <= CNT_RST;
      pre_rld_r <= CNT_RST;
      pre_run_r <= 1'b0;
    end else if (is_op(i_cmd, OP_LOAD_PRESCALER_AND_RELOAD)) begin
      pre_cnt_r <= dat;
      pre_rld_r <= dat;
    end else if (is_op(i_cmd, OP_WRITE_PRESCALER_CONTROL)) begin
      pre_run_r <= i_cmd.lo[PA_RUN_BIT];
      if (!i_cmd.lo[PA_RUN_BIT]) begin
        pre_cnt_r <= pre_rld_r;
      end
    end else if (pre_uf) begin
      pre_cnt_r <= pre_rld_r;
    end else if (pre_tick) begin
      pre_cnt_r <= pre_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_div2_r <= 1'b0;
      pre_out_r  <= 1'b0;
    end else begin
      pre_out_r <= pre_uf;
      if (pre_uf) begin
        pre_div2_r <= ~pre_div2_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      w1_r <= CTL_RST;
      w2_r <= CTL_RST;
      w3_r <= CTL_RST;
      w4_r <= CTL_RST;
      w6_r <= CTL_RST;
    end else begin
      if (is_op(i_cmd, OP_WRITE_FIRST_CONTROL)) begin
        w1_r <= i_cmd.lo;
      end
      if (is_op(i_cmd, OP_WRITE_SECOND_CONTROL)) begin
        w2_r <= i_cmd.lo;
      end
      if (is_op(i_cmd, OP_WRITE_THIRD_CONTROL)) begin
        w3_r <= i_cmd.lo;
      end
      if (is_op(i_cmd, OP_WRITE_FOURTH_CONTROL)) begin
        w4_r <= i_cmd.lo;
      end
      if (is_op(i_cmd, OP_WRITE_PIN_CONTROL)) begin
        w6_r <= i_cmd.lo;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count sources, loads and reloads

  // Source changes are only safe with the timer stopped
  always_comb begin
    tick[0] = 1'b0;
    case (w1_r[SRC_LSB+:2])
      SRC_SEL0: tick[0] = i_instruction_clock;
      SRC_SEL1: tick[0] = pre_uf;
      SRC_SEL2: tick[0] = i_fifth_timer_underflow;
      SRC_SEL3: tick[0] = pin0_rise;
      default:  tick[0] = 1'b0;
    endcase
    tick[0] = tick[0] & w1_r[RUN_BIT] & (~i_first_irq_pin_control | sync0_r);
    tick[1] = 1'b0;
    case (w2_r[SRC_LSB+:2])
      SRC_SEL0: tick[1] = i_system_clock;
      SRC_SEL1: tick[1] = pre_uf;
      SRC_SEL2: tick[1] = uflow[0];
      SRC_SEL3: tick[1] = pwm_rise;
      default:  tick[1] = 1'b0;
    endcase
    tick[1] = tick[1] & w2_r[RUN_BIT];
    tick[2] = 1'b0;
    case (w3_r[SRC_LSB+:2])
      SRC_SEL0: tick[2] = pwm_rise;
      SRC_SEL1: tick[2] = pre_uf;
      SRC_SEL2: tick[2] = uflow[1];
      SRC_SEL3: tick[2] = pin1_rise;
      default:  tick[2] = 1'b0;
    endcase
    tick[2] = tick[2] & w3_r[RUN_BIT] & (~i_second_irq_pin_control | sync1_r);
    // Waiting out the half period holds the fourth counter
    tick[3] = src4 & (w4_r[T4_RUN_BIT] | hold4_r) & ~ext_wait_r;
  end

  assign src4 = w4_r[T4_SRC_BIT] ? (pre_uf & pre_div2_r) : i_xin_clock;

  always_comb begin
    uflow[0] = tick[0] && (cnt_r[0] == 8'h00);
    uflow[1] = tick[1] && (cnt_r[1] == 8'h00);
    uflow[2] = tick[2] && (cnt_r[2] == 8'h00);
    uflow[3] = (tick[3] && (cnt_r[3] == 8'h00) && !ext_cond) || ext_done;
    ld_cnt[0] = is_op(i_cmd, OP_LOAD_FIRST_TIMER);
    ld_cnt[1] = is_op(i_cmd, OP_LOAD_SECOND_TIMER);
    ld_cnt[2] = is_op(i_cmd, OP_LOAD_THIRD_TIMER);
    ld_cnt[3] = is_op(i_cmd, OP_LOAD_FOURTH_TIMER) |
                is_op(i_cmd, OP_RESTORE_FOURTH_FROM_LOW);
    ld_rld[0] = ld_cnt[0] | is_op(i_cmd, OP_LOAD_FIRST_RELOAD_ONLY);
    ld_rld[1] = ld_cnt[1];
    ld_rld[2] = ld_cnt[2] | is_op(i_cmd, OP_LOAD_THIRD_RELOAD_ONLY);
    ld_rld[3] = is_op(i_cmd, OP_LOAD_FOURTH_TIMER);
    ld_val[0] = dat;
    ld_val[1] = dat;
    ld_val[2] = dat;
    ld_val[3] = is_op(i_cmd, OP_RESTORE_FOURTH_FROM_LOW) ? rld_r[3] : dat;
    rel_val[0] = rld_r[0];
    rel_val[1] = rld_r[1];
    rel_val[2] = rld_r[2];
    rel_val[3] = (w4_r[T4_OUT_BIT] && !pwm_r) ? hi_rld_r : rld_r[3];
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tmr
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cnt_r[g] <= CNT_RST;
        end else if (ld_cnt[g]) begin
          cnt_r[g] <= ld_val[g];
        end else if (uflow[g]) begin
          cnt_r[g] <= rel_val[g];
        end else if (tick[g] && (cnt_r[g] != 8'h00)) begin
          cnt_r[g] <= cnt_r[g] - 8'h01;
        end
      end

      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          rld_r[g] <= CNT_RST;
        end else if (ld_rld[g]) begin
          rld_r[g] <= dat;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hi_rld_r <= CNT_RST;
    end else if (is_op(i_cmd, OP_LOAD_FOURTH_HIGH_RELOAD)) begin
      hi_rld_r <= dat;
    end
  end

  // A new underflow beats a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_r <= 4'h0;
    end else begin
      flag_r <= uflow | (flag_r & ~i_flag_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start synchronisation and auto-stop

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync0_r <= 1'b0;
      sync1_r <= 1'b0;
    end else begin
      if (!i_first_irq_pin_control) begin
        sync0_r <= 1'b0;
      end else if (i_ext_trigger_pin_zero) begin
        sync0_r <= 1'b1;
      end else if (uflow[0] && w1_r[AUTOSTOP_BIT]) begin
        sync0_r <= 1'b0;
      end
      if (!i_second_irq_pin_control) begin
        sync1_r <= 1'b0;
      end else if (i_ext_trigger_pin_one) begin
        sync1_r <= 1'b1;
      end else if (uflow[2] && w3_r[AUTOSTOP_BIT]) begin
        sync1_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fourth timer PWM, half-period stretch and run-out

  assign ext_cond  = w4_r[T4_EXT_BIT] & w4_r[T4_OUT_BIT] & pwm_r;
  assign ext_start = tick[3] && (cnt_r[3] == 8'h00) && ext_cond;
  assign ext_done  = ext_wait_r && (ext_cnt_r == {{(PER_W-1){1'b0}}, 1'b1});
  assign half      = (per_r[PER_W-1:1] == '0) ? {{(PER_W-1){1'b0}}, 1'b1}
                                              : {1'b0, per_r[PER_W-1:1]};

  // Half period is measured in clocks from the last source period
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      per_cnt_r <= '0;
      per_r     <= '0;
    end else if (src4) begin
      per_r     <= (per_cnt_r == PER_MAX) ? PER_MAX : per_cnt_r + 16'h0001;
      per_cnt_r <= '0;
    end else if (per_cnt_r != PER_MAX) begin
      per_cnt_r <= per_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_wait_r <= 1'b0;
      ext_cnt_r  <= '0;
    end else if (ext_start && !ext_wait_r) begin
      ext_wait_r <= 1'b1;
      ext_cnt_r  <= half;
    end else if (ext_done) begin
      ext_wait_r <= 1'b0;
    end else if (ext_wait_r) begin
      ext_cnt_r <= ext_cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hold4_r <= 1'b0;
    end else if (uflow[3]) begin
      hold4_r <= 1'b0;
    end else if (is_op(i_cmd, OP_WRITE_FOURTH_CONTROL) && !i_cmd.lo[T4_RUN_BIT] &&
                 w4_r[T4_RUN_BIT] && pwm_r) begin
      hold4_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwm_r   <= 1'b0;
      pwm_d_r <= 1'b0;
    end else begin
      pwm_d_r <= pwm_r;
      if (!w4_r[T4_OUT_BIT]) begin
        pwm_r <= 1'b0;
      end else if (uflow[3]) begin
        pwm_r <= ~pwm_r;
      end
    end
  end

  // Gate starts enabled and returns there whenever the third timer's run bit is clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gate_r <= 1'b1;
    end else if (!w3_r[RUN_BIT]) begin
      gate_r <= 1'b1;
    end else if (w6_r[PWM_GATE_BIT] && uflow[2]) begin
      gate_r <= ~gate_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter pins

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      t1_half_r <= 1'b0;
      t2_half_r <= 1'b0;
      pin0_d_r  <= 1'b0;
      pin1_d_r  <= 1'b0;
      pins_r    <= '{counter_pin_zero: 1'b0, counter_pin_zero_oe_n: 1'b1, counter_pin_one: 1'b0, counter_pin_one_oe_n: 1'b1};
    end else begin
      pin0_d_r <= i_counter_pin_zero;
      pin1_d_r <= i_counter_pin_one;
      if (uflow[0]) begin
        t1_half_r <= ~t1_half_r;
      end
      if (uflow[1]) begin
        t2_half_r <= ~t2_half_r;
      end
      pins_r.counter_pin_zero      <= w2_r[OUTSEL_BIT] ? t2_half_r : t1_half_r;
      pins_r.counter_pin_zero_oe_n <= ~w6_r[PIN0_FUNC_BIT];
      pins_r.counter_pin_one      <= pwm_r & (~w6_r[PWM_GATE_BIT] | gate_r);
      // Pin one turns input while it feeds the third timer
      pins_r.counter_pin_one_oe_n <= (w3_r[SRC_LSB+:2] == SRC_SEL3);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reads; counters read reliably only while stopped

  always_comb begin
    rd_req = i_cmd.valid;
    rd_nxt = 8'h00;
    case (i_cmd.op)
      OP_READ_PRESCALER_RELOAD: rd_nxt = pre_rld_r;
      OP_READ_FIRST_TIMER:      rd_nxt = cnt_r[0];
      OP_READ_SECOND_TIMER:     rd_nxt = cnt_r[1];
      OP_READ_THIRD_TIMER:      rd_nxt = cnt_r[2];
      OP_READ_FOURTH_TIMER:     rd_nxt = cnt_r[3];
      OP_READ_FIRST_CONTROL:    rd_nxt = {4'h0, w1_r};
      OP_READ_SECOND_CONTROL:   rd_nxt = {4'h0, w2_r};
      OP_READ_THIRD_CONTROL:    rd_nxt = {4'h0, w3_r};
      OP_READ_FOURTH_CONTROL:   rd_nxt = {4'h0, w4_r};
      OP_READ_PIN_CONTROL:      rd_nxt = {4'h0, w6_r};
      default:                  rd_req = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_req;
      if (rd_req) begin
        rd_data_r <= rd_nxt;
      end
    end
  end

  assign o_rd_data            = rd_data_r;
  assign o_rd_valid           = rd_valid_r;
  assign o_flags              = flag_r;
  assign o_prescaler_output   = pre_out_r;
  assign o_pulse_width_output = pwm_r;
  assign o_pins               = pins_r;

endmodule

`default_nettype wire

// ---- dv/prt_cpu_model.sv ----
// Behavioural CPU core issuing transfer instructions to the timers
`default_nettype none
module prt_cpu_model
  import prt_pkg::*;
(
  input  wire logic i_clk,
  output var prt_cmd_t o_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_cmd = '0;
  ////////////////////////////////////////////////////////////////////////////
  // One instruction a cycle; callers stop a counter before load or read
  task automatic issue(input prt_op_t op, input logic [7:0] d);
    @(negedge i_clk);
    o_cmd <= {1'b1, op, d};
  endtask
  task automatic idle();
    @(negedge i_clk);
    o_cmd <= '0;
  endtask
endmodule
`default_nettype wire

// ---- dv/prt_timers_assertions.sv ----
// Port checker for the prescaler and reload timers
`default_nettype none
module prt_timers_checker
  import prt_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire prt_cmd_t   i_cmd,
  input wire logic       i_instruction_clock,
  input wire logic [3:0] i_flag_clr,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_rd_valid,
  input wire logic [3:0] o_flags,
  input wire logic       o_prescaler_output,
  input wire logic       o_pulse_width_output,
  input wire prt_pins_t  o_pins
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic rd_op;
  logic wr_pin;
  logic wr_t3;
  logic wr_t4;
  assign rd_op = i_cmd.valid && (i_cmd.op inside {OP_READ_PRESCALER_RELOAD,
    OP_READ_FIRST_TIMER, OP_READ_SECOND_TIMER, OP_READ_THIRD_TIMER,
    OP_READ_FOURTH_TIMER, OP_READ_FIRST_CONTROL, OP_READ_SECOND_CONTROL,
    OP_READ_THIRD_CONTROL, OP_READ_FOURTH_CONTROL, OP_READ_PIN_CONTROL});
  assign wr_pin = i_cmd.valid && i_cmd.op == OP_WRITE_PIN_CONTROL;
  assign wr_t3 = i_cmd.valid && i_cmd.op == OP_WRITE_THIRD_CONTROL;
  assign wr_t4 = i_cmd.valid && i_cmd.op == OP_WRITE_FOURTH_CONTROL;
  ////////////////////////////////////////////////////////////////////////////
  AST_RD_ANSWER: assert property (rd_op |=> o_rd_valid)
    else $error("read without answer");
  AST_RD_ONLY: assert property (!rd_op |=> !o_rd_valid)
    else $error("answer without read");
  AST_RD_HOLD: assert property (!o_rd_valid |-> $stable(o_rd_data))
    else $error("read data moved");
  AST_CTL_BACK: assert property ((i_cmd.valid && i_cmd.op == OP_WRITE_FIRST_CONTROL)
    ##1 (i_cmd.valid && i_cmd.op == OP_READ_FIRST_CONTROL)
    |=> o_rd_data == {4'h0, $past(i_cmd.lo, 2)})
    else $error("control readback wrong");
  AST_PSC_CAUSE: assert property (o_prescaler_output |-> $past(i_instruction_clock))
    else $error("prescaler pulse without tick");
  AST_FLAG_STICKY: assert property (1'b1 |=>
    ((o_flags & $past(o_flags & ~i_flag_clr)) == $past(o_flags & ~i_flag_clr)))
    else $error("flag lost without clear");
  AST_PIN0_OE: assert property (wr_pin |->
    ##2 (o_pins.counter_pin_zero_oe_n == !$past(i_cmd.lo[PIN0_FUNC_BIT], 2)))
    else $error("counter pin zero enable wrong");
  AST_PIN1_OE: assert property (wr_t3 |->
    ##2 (o_pins.counter_pin_one_oe_n == ($past(i_cmd.lo[1:0], 2) == SRC_SEL3)))
    else $error("counter pin one enable wrong");
  AST_PWM_OFF: assert property (wr_t4 && !i_cmd.lo[T4_OUT_BIT] |->
    ##2 !o_pulse_width_output [*3])
    else $error("pulse output not forced low");
  COV_READ: cover property (rd_op);
  COV_PWM: cover property ($rose(o_pulse_width_output));
  COV_FLAGS: cover property (o_flags == 4'hf);
endmodule

bind prt_timers prt_timers_checker u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_cmd(i_cmd), .i_instruction_clock(i_instruction_clock), .i_flag_clr(i_flag_clr),
  .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_flags(o_flags),
  .o_prescaler_output(o_prescaler_output),
  .o_pulse_width_output(o_pulse_width_output), .o_pins(o_pins));
`default_nettype wire

// ---- dv/test_prt_timers.sv ----
// Self-checking bench for the prescaler and reload timers
`default_nettype none
module test_prt_timers import prt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       tick = 1'b0;
  logic       trig = 1'b0;
  logic       sync_en = 1'b0;
  logic [3:0] clr = 4'h0;
  prt_cmd_t   cmd;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic [3:0] flags;
  logic       psc;
  logic       pwm;
  prt_pins_t  pins;
  logic       p;
  int         fail_count = 0;
  int         checked = 0;
  int         cycles = 0;
  int         pulses = 0;
  int         hi;
  prt_op_t    ctl_rd[5] = '{OP_READ_FIRST_CONTROL, OP_READ_SECOND_CONTROL,
    OP_READ_THIRD_CONTROL, OP_READ_FOURTH_CONTROL, OP_READ_PIN_CONTROL};
  prt_op_t    ld[4] = '{OP_LOAD_FIRST_TIMER, OP_LOAD_SECOND_TIMER,
    OP_LOAD_THIRD_TIMER, OP_LOAD_FOURTH_TIMER};
  prt_op_t    cnt_rd[4] = '{OP_READ_FIRST_TIMER, OP_READ_SECOND_TIMER,
    OP_READ_THIRD_TIMER, OP_READ_FOURTH_TIMER};

  always #4 clk = ~clk;
  prt_cpu_model cpu (.i_clk(clk), .o_cmd(cmd));
  prt_timers dut (.i_clk(clk), .i_rstn(rstn), .i_cmd(cmd),
    .i_instruction_clock(tick), .i_system_clock(tick), .i_xin_clock(tick),
    .i_fifth_timer_underflow(1'b0), .i_counter_pin_zero(1'b0),
    .i_counter_pin_one(1'b0), .i_ext_trigger_pin_zero(trig),
    .i_ext_trigger_pin_one(trig), .i_first_irq_pin_control(sync_en),
    .i_second_irq_pin_control(sync_en), .i_flag_clr(clr), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_flags(flags), .o_prescaler_output(psc),
    .o_pulse_width_output(pwm), .o_pins(pins));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Pulses sampled mid-cycle, clear of the launching edge
  always @(negedge clk) begin
    if (psc === 1'b1) pulses++;
  end
  // Whole run is well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input prt_op_t op, input logic [7:0] d);
    cpu.issue(op, d);
    cpu.idle();
  endtask
  task automatic rd(input prt_op_t op, input logic [7:0] exp, input string what);
    wr(op, 8'h00);
    // Answer stands only in the cycle after the read
    check("rd_valid", {7'h0, rd_valid}, 8'h01);
    check(what, rd_data, exp);
  endtask
  // Ticks every other cycle so each one is a single count
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clk);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
    end
  endtask
  task automatic clear();
    @(negedge clk);
    clr = 4'hf;
    @(negedge clk);
    clr = 4'h0;
  endtask
  // Ten whole periods after a settling time
  task automatic high_cycles(input logic [7:0] exp, input string what);
    repeat (14) @(negedge clk);
    hi = 0;
    repeat (70) begin
      @(negedge clk);
      hi += pwm + pins.counter_pin_one;
    end
    check(what, hi[7:0], exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    foreach (ctl_rd[i]) rd(ctl_rd[i], 8'h00, "control reset");
    check("flags", {4'h0, flags}, 8'h00);
    check("pins", {4'h0, pins}, 8'h04);
    $display("test reset done");
    wr(OP_LOAD_PRESCALER_AND_RELOAD, 8'h03);
    wr(OP_WRITE_PRESCALER_CONTROL, 8'h01);
    ticks(20);
    wr(OP_WRITE_PRESCALER_CONTROL, 8'h00);
    check("prescaler pulses", pulses[7:0], 8'h05);
    ticks(8);
    check("stopped pulses", pulses[7:0], 8'h05);
    rd(OP_READ_PRESCALER_RELOAD, 8'h03, "prescaler reload");
    $display("test prescaler done");
    wr(OP_LOAD_PRESCALER_AND_RELOAD, 8'h00);
    wr(OP_WRITE_PRESCALER_CONTROL, 8'h01);
    foreach (ld[i]) wr(ld[i], 8'h04);
    wr(OP_WRITE_FIRST_CONTROL, 8'h04);
    wr(OP_WRITE_SECOND_CONTROL, 8'h04);
    wr(OP_WRITE_THIRD_CONTROL, 8'h05);
    wr(OP_WRITE_FOURTH_CONTROL, 8'h02);
    ticks(12);
    cpu.issue(OP_WRITE_FIRST_CONTROL, 8'h03);
    rd(OP_READ_FIRST_CONTROL, 8'h03, "first control");
    wr(OP_WRITE_SECOND_CONTROL, 8'h00);
    wr(OP_WRITE_THIRD_CONTROL, 8'h03);
    wr(OP_WRITE_FOURTH_CONTROL, 8'h00);
    foreach (cnt_rd[i]) rd(cnt_rd[i], 8'h02, "counter");
    check("flags", {4'h0, flags}, 8'h0f);
    check("counter_pin_one oe_n", {7'h0, pins.counter_pin_one_oe_n}, 8'h01);
    clear();
    check("flags cleared", {4'h0, flags}, 8'h00);
    $display("test four timers done");
    wr(OP_LOAD_FIRST_RELOAD_ONLY, 8'h07);
    wr(OP_LOAD_THIRD_RELOAD_ONLY, 8'h07);
    rd(OP_READ_THIRD_TIMER, 8'h02, "third kept");
    wr(OP_WRITE_FIRST_CONTROL, 8'h04);
    ticks(3);
    wr(OP_WRITE_FIRST_CONTROL, 8'h00);
    rd(OP_READ_FIRST_TIMER, 8'h07, "new reload");
    wr(OP_RESTORE_FOURTH_FROM_LOW, 8'h00);
    rd(OP_READ_FOURTH_TIMER, 8'h04, "restored");
    clear();
    sync_en = 1'b1;
    wr(OP_LOAD_FIRST_TIMER, 8'h02);
    wr(OP_LOAD_THIRD_TIMER, 8'h02);
    wr(OP_WRITE_FIRST_CONTROL, 8'h0c);
    wr(OP_WRITE_THIRD_CONTROL, 8'h0d);
    ticks(5);
    check("untriggered flags", {4'h0, flags}, 8'h00);
    trig = 1'b1;
    @(negedge clk);
    trig = 1'b0;
    ticks(10);
    wr(OP_WRITE_FIRST_CONTROL, 8'h00);
    rd(OP_READ_FIRST_TIMER, 8'h02, "auto stop");
    wr(OP_WRITE_THIRD_CONTROL, 8'h00);
    rd(OP_READ_THIRD_TIMER, 8'h02, "third auto stop");
    check("stop flag", {4'h0, flags}, 8'h05);
    sync_en = 1'b0;
    $display("test reload and trigger done");
    wr(OP_WRITE_PIN_CONTROL, 8'h01);
    wr(OP_LOAD_FIRST_TIMER, 8'h00);
    wr(OP_LOAD_SECOND_TIMER, 8'h01);
    wr(OP_WRITE_FIRST_CONTROL, 8'h04);
    p = pins.counter_pin_zero;
    ticks(1);
    @(negedge clk);
    check("counter_pin_zero oe_n", {7'h0, pins.counter_pin_zero_oe_n}, 8'h00);
    check("counter_pin_zero first", {7'h0, pins.counter_pin_zero}, {7'h0, ~p});
    wr(OP_WRITE_SECOND_CONTROL, 8'h0c);
    // Pin follows the new selection one edge late
    @(negedge clk);
    p = pins.counter_pin_zero;
    ticks(2);
    @(negedge clk);
    check("counter_pin_zero second", {7'h0, pins.counter_pin_zero}, {7'h0, ~p});
    wr(OP_WRITE_SECOND_CONTROL, 8'h00);
    wr(OP_WRITE_FIRST_CONTROL, 8'h00);
    $display("test counter pin done");
    wr(OP_LOAD_FOURTH_TIMER, 8'h03);
    wr(OP_LOAD_FOURTH_HIGH_RELOAD, 8'h02);
    wr(OP_WRITE_FOURTH_CONTROL, 8'h0a);
    tick = 1'b1;
    high_cycles(8'h3c, "high cycles");
    wr(OP_LOAD_THIRD_TIMER, 8'h00);
    wr(OP_WRITE_PIN_CONTROL, 8'h03);
    wr(OP_WRITE_THIRD_CONTROL, 8'h04);
    // Gate flips each period, so the pin keeps half its high cycles
    high_cycles(8'h2d, "gated high cycles");
    wr(OP_WRITE_THIRD_CONTROL, 8'h00);
    high_cycles(8'h3c, "gate cancelled");
    hi = 0;
    // First high cycle: pin copy still low
    while (!(pwm === 1'b1 && pins.counter_pin_one === 1'b0) && hi < 20) begin
      @(negedge clk);
      hi++;
    end
    // Stop lands mid high interval, away from an underflow
    wr(OP_WRITE_FOURTH_CONTROL, 8'h08);
    repeat (4) @(negedge clk);
    tick = 1'b0;
    check("pwm after stop", {7'h0, pwm}, 8'h00);
    rd(OP_READ_FOURTH_TIMER, 8'h03, "ran to underflow");
    wr(OP_WRITE_FOURTH_CONTROL, 8'h00);
    $display("test pulse width done");
    summarize();
  end
endmodule
`default_nettype wire
